// file: hw/lptp_pkg.sv
// Shared constants for the truncate/precharge command block.
// Assumes command/address bits arrive split into rising and falling halves.
package lptp_pkg;

	localparam int NBANK = 8;

	// Command/address bit positions, rising half unless noted
	localparam int CA_B0   = 0;
	localparam int CA_B1   = 1;
	localparam int CA_B2   = 2;
	localparam int CA_B3   = 3;
	localparam int AB_BIT  = 4;
	localparam int BA0_BIT = 7;
	localparam int BA1_BIT = 8;
	localparam int BA2_BIT = 9;
	localparam int AP_BIT  = 0;  // falling half

	// Burst length select codes and their half lengths in clocks
	localparam logic [1:0] BL_CODE_4 = 2'h0;
	localparam logic [1:0] BL_CODE_8 = 2'h1;
	localparam logic [5:0] HALF_BL4  = 6'h02;
	localparam logic [5:0] HALF_BL8  = 6'h04;
	localparam logic [5:0] HALF_BL16 = 6'h08;

	localparam logic [5:0] ONE_CYC   = 6'h01;
	localparam logic [5:0] PREF_CYC  = 6'h02;  // clocks per 4-beat prefetch
	localparam logic [7:0] ALL_BANKS = 8'hFF;
	localparam logic [7:0] ONE_BANK  = 8'h01;
	localparam logic [7:0] LOW_BANKS = 8'h0F;

	typedef enum logic [2:0] {
		LPTP_IDLE = 3'b001,
		LPTP_RD   = 3'b010,
		LPTP_WR   = 3'b100
	} lptp_burst_e;

endpackage

// file: hw/lptp_sync.sv
// Two-flop synchroniser for slow levels.
// Assumes multi-bit inputs are quasi-static, changing only while idle.
`timescale 1ns/1ps
`default_nettype none
module lptp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] in_d,
	output logic      [W-1:0] out_q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
	} lptp_sync_s;

	lptp_sync_s q;
	lptp_sync_s nxt_q;

	always_comb begin
		nxt_q.meta = in_d;
		nxt_q.stab = q.meta;
	end

	// No reset: the chain flushes itself within two edges
	always_ff @(posedge clk) begin
		q <= nxt_q;
	end

	assign out_q = q.stab;
endmodule
`default_nettype wire

// file: hw/lptp_ap_timer.sv
// Per-bank auto-close countdown on the link clock.
// Assumes load carries a delay of at least one clock.
`timescale 1ns/1ps
`default_nettype none
module lptp_ap_timer (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       load,
	input  wire logic [5:0] dly,
	output logic            fire
);
	typedef struct packed {
		logic       run;
		logic [5:0] cnt;
		logic       fire;
	} lptp_tmr_s;

	lptp_tmr_s q;
	lptp_tmr_s nxt_q;

	always_comb begin
		nxt_q = q;
		if (load) begin
			nxt_q.run = 1'b1;
			nxt_q.cnt = dly;
		end else if (q.run) begin
			nxt_q.cnt = q.cnt - 6'h01;
			if (q.cnt == 6'h01) begin
				nxt_q.run = 1'b0;
			end
		end
		// Fire is seen by the controller on the edge the count expires
		nxt_q.fire = nxt_q.run && (nxt_q.cnt == 6'h01);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= nxt_q;
		end
	end

	assign fire = q.fire;
endmodule
`default_nettype wire

// file: hw/lptp_ctrl.sv
// Device-side command block: burst truncate, write mask, precharge, auto-close.
// Assumes link_ck is the memory clock; config is static while bursts run.
// Contract
// - Write data capture stops write latency clocks after the truncate.
// - Read data drive stops read latency clocks after the truncate.
// - An asserted byte mask leaves that byte of that beat unwritten.
// - Byte masks are sampled exactly like the data bits of their lane.
// - Precharge decodes as chip select low, bits 1,1,0,1.
// - All-banks flag closes all; else bank bits pick one, four-bank ignores top.
// - Array writes happen only per complete four-beat group.
// - Auto-close flag low leaves the bank open after the burst.
// - Auto-close flag is falling bit 0; high on READ engages auto-close.
// - Read auto-close starts at max of half burst, half minus two plus tRTP.
// - Truncate decodes as chip select low, bits 1,1,0,0.
// - Truncated length is twice the clocks from command to truncate.
// - Write auto-close starts one clock plus write recovery clocks after the burst ends.
`timescale 1ns/1ps
`default_nettype none
module lptp_ctrl (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        link_ck,
	input  wire logic        cs_n,
	input  wire logic [9:0]  ca_rise,
	input  wire logic [9:0]  ca_fall,
	input  wire logic [15:0] dq_rise_in,
	input  wire logic [15:0] dq_fall_in,
	input  wire logic [1:0]  mask_rise,
	input  wire logic [1:0]  mask_fall,
	input  wire logic [31:0] arr_rd_data,
	input  wire logic [3:0]  cfg_rl,
	input  wire logic [3:0]  cfg_wl,
	input  wire logic [3:0]  cfg_trtp,
	input  wire logic [3:0]  cfg_twr,
	input  wire logic [1:0]  cfg_bl,
	input  wire logic        cfg_eight_bank,
	output logic [15:0]      dq_rise_out,
	output logic [15:0]      dq_fall_out,
	output logic             dq_oe,
	output logic             arr_wr_stb,
	output logic [2:0]       arr_wr_bank,
	output logic [2:0]       arr_wr_grp,
	output logic [63:0]      arr_wr_data,
	output logic [7:0]       arr_wr_be,
	output logic             arr_rd_stb,
	output logic [2:0]       arr_rd_bank,
	output logic             bank_pre_stb,
	output logic [7:0]       bank_pre_mask,
	output logic [7:0]       bank_open_status
);
	typedef struct packed {
		lptp_pkg::lptp_burst_e st;
		logic [5:0]            cyc;
		logic [5:0]            half;
		logic [5:0]            lat;
		logic                  bst_seen;
		logic                  ap;
		logic [2:0]            bank;
		logic [7:0]            open;
		logic [31:0]           grp_data;
		logic [3:0]            grp_be;
		logic [31:0]           dq_out;
		logic                  dq_oe;
		logic                  wr_stb;
		logic [2:0]            wr_grp;
		logic [63:0]           wr_data;
		logic [7:0]            wr_be;
		logic                  rd_stb;
		logic                  pre_stb;
		logic [7:0]            pre_mask;
	} lptp_link_s;

	lptp_link_s q;
	lptp_link_s nxt_q;
	logic       rst_link;
	logic [18:0] cfg_ls;
	logic [7:0] ap_load;
	logic [7:0] ap_fire;
	logic [5:0] ap_dly;
	logic [5:0] rl6;
	logic [5:0] wl6;
	logic [5:0] trtp6;
	logic [5:0] twr6;
	logic [5:0] cfg_half;
	logic       eight_ls;
	logic       cmd_rd;
	logic       cmd_wr;
	logic       cmd_bst;
	logic       cmd_pre;
	logic       cmd_act;
	logic       bst_ok;
	logic [5:0] ecur;
	logic [5:0] idx;
	logic       win;
	logic [2:0] ba;
	logic [7:0] sel_mask;

	////////////////////////////////////////////////////////////////////////
	// Crossings: reset and static config into the link domain

	lptp_sync #(.W(1)) u_rst_sync (
		.clk   (link_ck),
		.in_d  (rst),
		.out_q (rst_link)
	);

	lptp_sync #(.W(19)) u_cfg_sync (
		.clk   (link_ck),
		.in_d  ({cfg_rl, cfg_wl, cfg_trtp, cfg_twr, cfg_bl, cfg_eight_bank}),
		.out_q (cfg_ls)
	);

	// Bank state back to the core clock; only read as a slow status level
	lptp_sync #(.W(8)) u_open_sync (
		.clk   (clk),
		.in_d  (q.open),
		.out_q (bank_open_status)
	);

	assign rl6      = {2'h0, cfg_ls[18:15]};
	assign wl6      = {2'h0, cfg_ls[14:11]};
	assign trtp6    = {2'h0, cfg_ls[10:7]};
	assign twr6     = {2'h0, cfg_ls[6:3]};
	assign eight_ls = cfg_ls[0];

	always_comb begin
		case (cfg_ls[2:1])
			lptp_pkg::BL_CODE_4: cfg_half = lptp_pkg::HALF_BL4;
			lptp_pkg::BL_CODE_8: cfg_half = lptp_pkg::HALF_BL8;
			default:             cfg_half = lptp_pkg::HALF_BL16;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Command decode at the rising link edge

	always_comb begin
		cmd_rd  = !cs_n && ca_rise[lptp_pkg::CA_B0] && !ca_rise[lptp_pkg::CA_B1]
			&& ca_rise[lptp_pkg::CA_B2];
		cmd_wr  = !cs_n && ca_rise[lptp_pkg::CA_B0] && !ca_rise[lptp_pkg::CA_B1]
			&& !ca_rise[lptp_pkg::CA_B2];
		cmd_bst = !cs_n && ca_rise[lptp_pkg::CA_B0] && ca_rise[lptp_pkg::CA_B1]
			&& !ca_rise[lptp_pkg::CA_B2] && !ca_rise[lptp_pkg::CA_B3];
		cmd_pre = !cs_n && ca_rise[lptp_pkg::CA_B0] && ca_rise[lptp_pkg::CA_B1]
			&& !ca_rise[lptp_pkg::CA_B2] && ca_rise[lptp_pkg::CA_B3];
		cmd_act = !cs_n && !ca_rise[lptp_pkg::CA_B0] && ca_rise[lptp_pkg::CA_B1];
		// Four-bank part folds the top bank bit away
		ba = {ca_rise[lptp_pkg::BA2_BIT] && eight_ls,
			ca_rise[lptp_pkg::BA1_BIT], ca_rise[lptp_pkg::BA0_BIT]};
		sel_mask = lptp_pkg::ONE_BANK << ba;
		// Truncate acts once per burst; auto-close bursts cannot be cut
		bst_ok = cmd_bst && (q.st != lptp_pkg::LPTP_IDLE) && !q.bst_seen
			&& !q.ap && (ecur < q.half);
	end

	////////////////////////////////////////////////////////////////////////
	// Auto-close timers, one per bank

	always_comb begin
		ap_load = '0;
		if (cmd_rd) begin
			// Later of half burst and (half - 2 + tRTP)
			ap_dly = (trtp6 > lptp_pkg::PREF_CYC)
				? cfg_half - lptp_pkg::PREF_CYC + trtp6 : cfg_half;
		end else begin
			ap_dly = wl6 + cfg_half + lptp_pkg::ONE_CYC + twr6;
		end
		if ((cmd_rd || cmd_wr) && ca_fall[lptp_pkg::AP_BIT]) begin
			ap_load = sel_mask;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < lptp_pkg::NBANK; gi++) begin : g_ap
			lptp_ap_timer u_tmr (
				.clk  (link_ck),
				.rst  (rst_link),
				.load (ap_load[gi]),
				.dly  (ap_dly),
				.fire (ap_fire[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Burst tracking, data window and bank state

	assign ecur = q.cyc + lptp_pkg::ONE_CYC;
	assign idx  = ecur - q.lat;
	assign win  = (q.st != lptp_pkg::LPTP_IDLE) && (ecur >= q.lat)
		&& (ecur < q.lat + q.half);

	always_comb begin
		nxt_q = q;
		nxt_q.wr_stb   = 1'b0;
		nxt_q.rd_stb   = 1'b0;
		nxt_q.pre_stb  = 1'b0;
		nxt_q.pre_mask = '0;
		nxt_q.dq_oe    = 1'b0;
		nxt_q.dq_out   = '0;
		if (q.st != lptp_pkg::LPTP_IDLE) begin
			nxt_q.cyc = ecur;
		end
		if (bst_ok) begin
			nxt_q.half     = ecur;
			nxt_q.bst_seen = 1'b1;
		end
		case (q.st)
			lptp_pkg::LPTP_RD: begin
				if (win) begin
					nxt_q.dq_oe  = 1'b1;
					nxt_q.dq_out = arr_rd_data;
					nxt_q.rd_stb = 1'b1;
				end
			end
			lptp_pkg::LPTP_WR: begin
				if (win && !idx[0]) begin
					nxt_q.grp_data = {dq_fall_in, dq_rise_in};
					nxt_q.grp_be   = ~{mask_fall, mask_rise};
				end else if (win) begin
					// Array sees only whole four-beat groups
					nxt_q.wr_stb  = 1'b1;
					nxt_q.wr_grp  = idx[3:1];
					nxt_q.wr_data = {dq_fall_in, dq_rise_in, q.grp_data};
					nxt_q.wr_be   = {~mask_fall, ~mask_rise, q.grp_be};
				end
			end
			default: begin
			end
		endcase
		// Window ends at latency plus (possibly truncated) half burst
		if (q.st != lptp_pkg::LPTP_IDLE && ecur >= q.lat + q.half) begin
			nxt_q.st = lptp_pkg::LPTP_IDLE;
		end
		// A new command restarts tracking; bank stays open unless flagged
		if (cmd_rd || cmd_wr) begin
			nxt_q.st       = cmd_rd ? lptp_pkg::LPTP_RD : lptp_pkg::LPTP_WR;
			nxt_q.cyc      = '0;
			nxt_q.half     = cfg_half;
			nxt_q.lat      = cmd_rd ? rl6 : wl6;
			nxt_q.bst_seen = 1'b0;
			nxt_q.ap       = ca_fall[lptp_pkg::AP_BIT];
			nxt_q.bank     = ba;
		end
		if (cmd_pre) begin
			nxt_q.pre_mask = ca_rise[lptp_pkg::AB_BIT]
				? lptp_pkg::ALL_BANKS : sel_mask;
		end
		nxt_q.pre_mask = nxt_q.pre_mask | ap_fire;
		nxt_q.pre_stb  = (nxt_q.pre_mask != '0);
		nxt_q.open     = q.open & ~nxt_q.pre_mask;
		if (cmd_act) begin
			nxt_q.open = nxt_q.open | sel_mask;
		end
	end

	always_ff @(posedge link_ck) begin
		if (rst_link) begin
			q    <= '0;
			q.st <= lptp_pkg::LPTP_IDLE;
		end else begin
			q <= nxt_q;
		end
	end

	assign dq_rise_out   = q.dq_out[15:0];
	assign dq_fall_out   = q.dq_out[31:16];
	assign dq_oe         = q.dq_oe;
	assign arr_wr_stb    = q.wr_stb;
	assign arr_wr_bank   = q.bank;
	assign arr_wr_grp    = q.wr_grp;
	assign arr_wr_data   = q.wr_data;
	assign arr_wr_be     = q.wr_be;
	assign arr_rd_stb    = q.rd_stb;
	assign arr_rd_bank   = q.bank;
	assign bank_pre_stb  = q.pre_stb;
	assign bank_pre_mask = q.pre_mask;

	////////////////////////////////////////////////////////////////////////
	// Checks on the link domain

	a_pre_decode: assert property (@(posedge link_ck) disable iff (rst_link)
		cmd_pre |=> bank_pre_stb)
		else $error("precharge not acted on");

	a_pre_all: assert property (@(posedge link_ck) disable iff (rst_link)
		cmd_pre && ca_rise[lptp_pkg::AB_BIT] |=> bank_pre_mask == 8'hFF)
		else $error("all-bank precharge missed a bank");

	a_pre_four: assert property (@(posedge link_ck) disable iff (rst_link)
		cmd_pre && !ca_rise[lptp_pkg::AB_BIT] && !eight_ls && ap_fire == '0
		|=> (bank_pre_mask & ~lptp_pkg::LOW_BANKS) == '0)
		else $error("four-bank precharge used top bank bit");

	a_bst_len: assert property (@(posedge link_ck) disable iff (rst_link)
		bst_ok |=> q.half == $past(q.cyc) + 6'h01 && q.bst_seen)
		else $error("truncated length wrong");

	a_wr_group: assert property (@(posedge link_ck) disable iff (rst_link)
		arr_wr_stb |-> $past(win, 1) && $past(win, 2))
		else $error("array write without a full group");

	a_mask_lane: assert property (@(posedge link_ck) disable iff (rst_link)
		arr_wr_stb |-> arr_wr_be[7:6] == ~$past(mask_fall))
		else $error("byte mask not honoured");

	a_rd_stop: assert property (@(posedge link_ck) disable iff (rst_link)
		q.st == lptp_pkg::LPTP_RD && ecur >= q.lat + q.half
		&& !(cmd_rd || cmd_wr) |=> !dq_oe ##1 !dq_oe)
		else $error("read data driven past end");

	a_wr_stop: assert property (@(posedge link_ck) disable iff (rst_link)
		q.st == lptp_pkg::LPTP_WR && ecur >= q.lat + q.half
		&& !(cmd_rd || cmd_wr) |=> !arr_wr_stb ##1 !arr_wr_stb)
		else $error("write data taken past end");

	a_keep_open: assert property (@(posedge link_ck) disable iff (rst_link)
		(cmd_rd || cmd_wr) && !ca_fall[lptp_pkg::AP_BIT] |-> ap_load == '0)
		else $error("auto-close armed with flag low");

	a_rd_close: assert property (@(posedge link_ck) disable iff (rst_link)
		cmd_rd && ca_fall[lptp_pkg::AP_BIT] |-> ap_load == sel_mask
		&& ap_dly >= cfg_half)
		else $error("read auto-close delay wrong");
endmodule
`default_nettype wire

// file: tb/lptp_host_model.sv
// Memory controller model: drives command/address, write data and masks.
// Assumes link_ck runs free; one call of step covers one link cycle.
`timescale 1ns/1ps
`default_nettype none
module lptp_host_model (
	input  wire logic        link_ck,
	output logic             cs_n,
	output logic [9:0]       ca_rise,
	output logic [9:0]       ca_fall,
	output logic [15:0]      dq_rise_in,
	output logic [15:0]      dq_fall_in,
	output logic [1:0]       mask_rise,
	output logic [1:0]       mask_fall
);
	initial begin
		cs_n = 1'b1;
		ca_rise = 10'h000;
		ca_fall = 10'h000;
		{dq_fall_in, dq_rise_in} = 32'h0000_0000;
		{mask_fall, mask_rise} = 4'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// Lines change after the falling edge so the rising edge sees them settled
	task automatic step(input logic go, input logic [9:0] car,
		input logic [9:0] caf, input logic dv, input logic [31:0] d,
		input logic [3:0] m);
		@(negedge link_ck);
		cs_n = ~go;
		ca_rise = go ? car : ~ca_rise;
		ca_fall = go ? caf : ~ca_fall;
		// Released lines toggle so a stale value never passes as valid
		{dq_fall_in, dq_rise_in} = dv ? d : ~{dq_fall_in, dq_rise_in};
		{mask_fall, mask_rise} = dv ? m : ~{mask_fall, mask_rise};
	endtask

	// Idle gaps keep every bank spacing the device expects
	task automatic idle(input int n);
		repeat (n) step(1'b0, 10'h000, 10'h000, 1'b0, 32'h0, 4'h0);
	endtask
endmodule
`default_nettype wire

// file: tb/lpddr2_truncate_precharge_ctrl_bench.sv
// Self-checking bench for the truncate/precharge command block.
// Assumes the host model owns the link pins and the bench owns config.
`timescale 1ns/1ps
`default_nettype none
module lpddr2_truncate_precharge_ctrl_bench;
	localparam logic [3:0] OP_RD = 4'h5;
	localparam logic [3:0] OP_WR = 4'h1;
	localparam logic [3:0] OP_TR = 4'h3;
	localparam logic [3:0] OP_PRE = 4'hB;
	localparam logic [3:0] OP_ACT = 4'h2;
	logic        clk, rst, link_ck, cs_n, dq_oe, arr_wr_stb, arr_rd_stb;
	logic        bank_pre_stb, cfg_eight_bank;
	logic [9:0]  ca_rise, ca_fall;
	logic [15:0] dq_rise_in, dq_fall_in, dq_rise_out, dq_fall_out;
	logic [1:0]  mask_rise, mask_fall, cfg_bl;
	logic [31:0] arr_rd_data, rd_prev;
	logic [3:0]  cfg_rl, cfg_wl, cfg_trtp, cfg_twr;
	logic [2:0]  arr_wr_bank, arr_wr_grp, arr_rd_bank, wgrp, wbank, ebank;
	logic [63:0] arr_wr_data, wdat;
	logic [7:0]  arr_wr_be, bank_pre_mask, bank_open_status, wbe, pmask;
	int          miscompares, tests_run, lcyc, pre_at, pcnt, wcnt, rcnt;
	int          cyc, c, k, j;
	// {eight_bank, all_banks, bank[2:0], 3'b0, expected mask}
	logic [15:0] rows [7] = '{16'h8001, 16'h9808, 16'hB880, 16'hD0FF,
		16'h2802, 16'h3808, 16'h2001};

	lptp_host_model host (.link_ck, .cs_n, .ca_rise, .ca_fall, .dq_rise_in,
		.dq_fall_in, .mask_rise, .mask_fall);
	lptp_ctrl dut (.clk, .rst, .link_ck, .cs_n, .ca_rise, .ca_fall,
		.dq_rise_in, .dq_fall_in, .mask_rise, .mask_fall, .arr_rd_data,
		.cfg_rl, .cfg_wl, .cfg_trtp, .cfg_twr, .cfg_bl, .cfg_eight_bank,
		.dq_rise_out, .dq_fall_out, .dq_oe, .arr_wr_stb, .arr_wr_bank,
		.arr_wr_grp, .arr_wr_data, .arr_wr_be, .arr_rd_stb, .arr_rd_bank,
		.bank_pre_stb, .bank_pre_mask, .bank_open_status);

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		link_ck = 1'b0;
		#7;
		forever #32 link_ck = ~link_ck;
	end
	always @(posedge link_ck) begin
		lcyc <= lcyc + 1;
		if (bank_pre_stb) begin
			pre_at <= lcyc;
			pmask <= bank_pre_mask;
			pcnt <= pcnt + 1;
		end
		if (arr_wr_stb) begin
			wcnt <= wcnt + 1;
			wdat <= arr_wr_data;
			wbe <= arr_wr_be;
			wgrp <= arr_wr_grp;
			wbank <= arr_wr_bank;
		end
		// Read data leaves one link edge after the array word is taken
		rd_prev <= arr_rd_data;
		if (dq_oe) begin
			rcnt <= rcnt + 1;
			check(64'({dq_fall_out, dq_rise_out}), 64'(rd_prev));
			check(64'(arr_rd_bank), 64'(ebank));
		end
		check(64'(arr_rd_stb), 64'(dq_oe));
	end
	always @(negedge link_ck) arr_rd_data <= arr_rd_data + 32'h0101_0101;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		if (miscompares == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Link edges from the command edge to the registered precharge pulse
	function automatic logic [63:0] dly();
		return 64'(pre_at - c - 1);
	endfunction
	task automatic cmd(input logic [3:0] op, input logic [2:0] ba,
		input logic ab, input logic ap);
		host.step(1'b1, {ba, 2'b00, ab, op}, {9'h000, ap}, 1'b1,
			32'h6666_5555, 4'h0);
		if (op != OP_TR) c = lcyc;
		if (op == OP_RD || op == OP_WR) ebank = ba;
	endtask
	task automatic wd(input logic [31:0] d, input logic [3:0] m);
		host.step(1'b0, 10'h000, 10'h000, 1'b1, d, m);
	endtask
	// Config crosses quasi-statically, so it only moves while idle
	task automatic setcfg(input logic [1:0] bl, input logic eight);
		host.idle(1);
		cfg_bl = bl;
		cfg_eight_bank = eight;
		host.idle(8);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		cfg_rl = 4'h3;
		cfg_wl = 4'h1;
		cfg_trtp = 4'h5;
		cfg_twr = 4'h3;
		cfg_bl = 2'h0;
		cfg_eight_bank = 1'b1;
		arr_rd_data = 32'h0;
		// Link logic needs several of its own edges to see reset
		host.idle(10);
		@(negedge clk) rst = 1'b0;
		host.idle(6);
		foreach (rows[i]) begin
			setcfg(2'h0, rows[i][15]);
			cmd(OP_PRE, rows[i][13:11], rows[i][14], 1'b0);
			host.idle(4);
			check(dly(), 64'h0);
			check(64'(pmask), 64'(rows[i][7:0]));
		end
		cmd(OP_ACT, 3'h1, 1'b0, 1'b0);
		host.idle(4);
		check(64'(bank_open_status), 64'h02);
		k = wcnt;
		cmd(OP_WR, 3'h1, 1'b0, 1'b0);
		wd(32'h2222_1111, 4'h4);
		wd(32'h4444_3333, 4'h0);
		host.idle(6);
		check(64'(wcnt - k), 64'h1);
		check(64'(wbe), 64'hFB);
		check(wdat & 64'hFFFF_FFFF_FF00_FFFF, 64'h4444_3333_2200_1111);
		check(64'(wgrp), 64'h0);
		check(64'(bank_open_status), 64'h02);
		cmd(OP_RD, 3'h1, 1'b0, 1'b1);
		host.idle(12);
		check(dly(), 64'h5);
		check(64'(pmask), 64'h02);
		check(64'(bank_open_status), 64'h00);
		cmd(OP_ACT, 3'h1, 1'b0, 1'b0);
		host.idle(4);
		cmd(OP_WR, 3'h1, 1'b0, 1'b1);
		wd(32'h8888_7777, 4'h0);
		wd(32'h0000_9999, 4'h0);
		host.idle(14);
		check(dly(), 64'h7);
		cmd(OP_ACT, 3'h1, 1'b0, 1'b0);
		setcfg(2'h1, 1'b1);
		k = rcnt;
		j = pcnt;
		cmd(OP_RD, 3'h1, 1'b0, 1'b0);
		host.idle(12);
		check(64'(rcnt - k), 64'h4);
		check(64'(pcnt - j), 64'h0);
		k = rcnt;
		cmd(OP_RD, 3'h1, 1'b0, 1'b0);
		host.idle(1);
		cmd(OP_TR, 3'h0, 1'b0, 1'b0);
		host.idle(12);
		check(64'(rcnt - k), 64'h2);
		setcfg(2'h2, 1'b1);
		k = wcnt;
		cmd(OP_WR, 3'h1, 1'b0, 1'b0);
		wd(32'h1234_5678, 4'h0);
		cmd(OP_TR, 3'h0, 1'b0, 1'b0);
		repeat (6) wd(32'h9ABC_DEF0, 4'h0);
		host.idle(8);
		check(64'(wcnt - k), 64'h1);
		// Longer latencies, short read-to-precharge branch, longer recovery
		host.idle(1);
		cfg_rl = 4'h5;
		cfg_wl = 4'h2;
		cfg_trtp = 4'h1;
		cfg_twr = 4'h6;
		host.idle(8);
		cmd(OP_ACT, 3'h2, 1'b0, 1'b0);
		host.idle(2);
		k = rcnt;
		cmd(OP_RD, 3'h2, 1'b0, 1'b1);
		host.idle(16);
		check(64'(rcnt - k), 64'h8);
		check(dly(), 64'h8);
		check(64'(pmask), 64'h04);
		cmd(OP_ACT, 3'h2, 1'b0, 1'b0);
		host.idle(2);
		k = wcnt;
		cmd(OP_WR, 3'h2, 1'b0, 1'b0);
		repeat (9) wd(32'h5A5A_A5A5, 4'h0);
		host.idle(4);
		check(64'(wcnt - k), 64'h4);
		check(64'(wgrp), 64'h3);
		check(64'(wbank), 64'h2);
		cmd(OP_WR, 3'h2, 1'b0, 1'b1);
		repeat (9) wd(32'h0F0F_F0F0, 4'h0);
		host.idle(12);
		check(dly(), 64'h11);
		check(64'(bank_open_status), 64'h02);
		cmd(OP_ACT, 3'h3, 1'b0, 1'b0);
		host.idle(4);
		check(64'(bank_open_status), 64'h0A);
		j = pcnt;
		// Mid-run reset closes every bank and must not fake a precharge
		@(negedge clk) rst = 1'b1;
		host.idle(6);
		@(negedge clk) rst = 1'b0;
		host.idle(6);
		check(64'(bank_open_status), 64'h00);
		check(64'(pcnt - j), 64'h0);
		cmd(OP_PRE, 3'h0, 1'b1, 1'b0);
		host.idle(4);
		check(dly(), 64'h0);
		check(64'(pmask), 64'hFF);
		complete_run();
	end
endmodule
`default_nettype wire
